// [rtl/odj_debug_channel.sv]
/*
 * On-chip debug channel: test port, debug instructions, break point unit,
 * CPU message byte with dirty flag, and security gating of the fuses.
 * Assumes the test clock stops outside frames and the CPU core supplies a
 * trace and accepts injected instruction words while halted.
 */
// Function
// - Break on flow change, single step, two program and two combined points.
// - Four points configure as 4P, 3P+1D, or 2P+2D single-address breaks.
// - Combined pair may instead form one masked range break, program or data.
// - Opcodes 8 to B are private debug access instructions.
// - Test port enabled only with port fuse programmed and disable bit clear.
// - Debug works only with debug fuse programmed and no lock bit set.
// - With lock bit one or two set, debug fuse programming is refused until a chip erase.
// - Debugger feeds CPU instructions through scan chain; device executes them.
// - CPU returns results through an I/O mapped message location.
// - CPU write stores the byte and sets the dirty flag.
// - CPU read gives low seven bits plus dirty flag as MSB.
// - Shared address reaches the channel only with fuse and debugger access.
// - Programming needs only the four test pins, no high voltage.
// - Programming covers flash, EEPROM, fuses and lock bits.
// - Lock protection matches parallel programming mode.
// - Instruction register is four bits wide.
// - All shift registers shift least significant bit first.
`timescale 1ns/1ps
module odj_debug_channel (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   tck,
    input  wire logic                   tms,
    input  wire logic                   tdi,
    output logic                        tdo,
    output logic                        tdo_oe,
    input  wire logic                   test_port_enable_fuse,
    input  wire logic                   debug_enable_fuse,
    input  wire logic                   test_port_disable_bit,
    input  wire logic                   lock_bit_one,
    input  wire logic                   lock_bit_two,
    input  wire logic                   chip_erase_done,
    input  wire logic                   fuse_prog_req,
    output logic                        fuse_prog_grant,
    input  wire odj_pkg::odj_cpu_trace_t cpu_trace,
    input  wire logic                   io_wr,
    input  wire logic                   io_rd,
    input  wire logic                   io_sel,
    input  wire logic [7:0]             io_wdata,
    output logic [7:0]                  io_rdata,
    output logic                        io_hit,
    output logic                        cpu_halt,
    output logic                        instr_valid,
    output logic [15:0]                 instr_word
);
    typedef enum logic [3:0] {
        TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SELDR = 4'h2, TS_CAPDR = 4'h3,
        TS_SHDR  = 4'h4, TS_EX1DR = 4'h5, TS_PSDR = 4'h6, TS_EX2DR = 4'h7,
        TS_UPDR  = 4'h8, TS_SELIR = 4'h9, TS_CAPIR = 4'ha, TS_SHIR = 4'hb,
        TS_EX1IR = 4'hc, TS_PSIR = 4'hd, TS_EX2IR = 4'he, TS_UPIR = 4'hf
    } odj_tap_t;

    // ************************************************************
    // Security gating
    // ************************************************************
    logic port_en, dbg_en, any_lock, erase_seen;
    assign any_lock = lock_bit_one | lock_bit_two;
    assign port_en  = test_port_enable_fuse & ~test_port_disable_bit;
    assign dbg_en   = port_en & debug_enable_fuse & ~any_lock;

    // Erase unlocks fuse programming until both lock bits read clear
    always_ff @(posedge clk_sys) begin
        if (rst)
            erase_seen <= 1'b0;
        else if (chip_erase_done)
            erase_seen <= 1'b1;
        else if (!any_lock)
            erase_seen <= 1'b0;
    end
    // Same protection as parallel mode; covers all fuse writes
    assign fuse_prog_grant = fuse_prog_req & (~any_lock | erase_seen);

    // ************************************************************
    // Test clock domain: TAP and scan chains (four pins only)
    // ************************************************************
    odj_tap_t           ts, next_ts;
    logic [odj_pkg::IR_W-1:0]    ir_sh, ir;
    logic [odj_pkg::BPCH_W-1:0]  bp_sh;
    odj_pkg::odj_bp_cfg_t        bp_cfg_t;
    logic [odj_pkg::INSCH_W-1:0] ins_sh;
    logic [15:0]                 ins_hold;
    logic                        ins_tog;
    logic [odj_pkg::DMSG_W-1:0]  dm_sh;
    logic [2:0]                  dm_ctl;
    logic                        clr_tog, bp_tog;
    logic                        run_tog;
    logic                        byp;
    logic                        port_en_t, dbg_en_t;
    logic [1:0]                  dirty_t;
    logic [7:0]                  byte_t;   // Stable while dirty, safe to sample
    logic                        is_dbg;

    odj_sync #(.W(2)) u_sync_en (
        .clk  (tck),
        .rst  (1'b0),
        .din  ({port_en, dbg_en}),
        .dout ({port_en_t, dbg_en_t})
    );

    always_comb begin
        next_ts = ts;
        case (ts)
            TS_RESET: next_ts = tms ? TS_RESET : TS_IDLE;
            TS_IDLE:  next_ts = tms ? TS_SELDR : TS_IDLE;
            TS_SELDR: next_ts = tms ? TS_SELIR : TS_CAPDR;
            TS_CAPDR: next_ts = tms ? TS_EX1DR : TS_SHDR;
            TS_SHDR:  next_ts = tms ? TS_EX1DR : TS_SHDR;
            TS_EX1DR: next_ts = tms ? TS_UPDR  : TS_PSDR;
            TS_PSDR:  next_ts = tms ? TS_EX2DR : TS_PSDR;
            TS_EX2DR: next_ts = tms ? TS_UPDR  : TS_SHDR;
            TS_UPDR:  next_ts = tms ? TS_SELDR : TS_IDLE;
            TS_SELIR: next_ts = tms ? TS_RESET : TS_CAPIR;
            TS_CAPIR: next_ts = tms ? TS_EX1IR : TS_SHIR;
            TS_SHIR:  next_ts = tms ? TS_EX1IR : TS_SHIR;
            TS_EX1IR: next_ts = tms ? TS_UPIR  : TS_PSIR;
            TS_PSIR:  next_ts = tms ? TS_EX2IR : TS_PSIR;
            TS_EX2IR: next_ts = tms ? TS_UPIR  : TS_SHIR;
            TS_UPIR:  next_ts = tms ? TS_SELDR : TS_IDLE;
            default:  next_ts = TS_RESET;
        endcase
    end

    // Port held in reset while disabled; no TRST pin exists
    always_ff @(posedge tck) begin
        if (!port_en_t)
            ts <= TS_RESET;
        else
            ts <= next_ts;
    end

    // Private codes open the debug chains only when debug is allowed
    assign is_dbg = dbg_en_t & (ir >= odj_pkg::IR_DBG0)
                  & (ir <= odj_pkg::IR_DBG3);

    always_ff @(posedge tck) begin
        if (ts == TS_RESET)
            ir <= odj_pkg::IR_IDCODE;
        else if (ts == TS_UPIR)
            ir <= ir_sh;
    end

    // LSB first in and out on every chain
    always_ff @(posedge tck) begin
        if (ts == TS_CAPIR)
            ir_sh <= odj_pkg::IR_CAPT;
        else if (ts == TS_SHIR)
            ir_sh <= {tdi, ir_sh[odj_pkg::IR_W-1:1]};
    end

    always_ff @(posedge tck) begin
        if (ts == TS_CAPDR)
            byp <= 1'b0;
        else if (ts == TS_SHDR)
            byp <= tdi;
    end

    always_ff @(posedge tck) begin
        if (ts == TS_SHDR && is_dbg) begin
            case (ir)
                odj_pkg::IR_DBG0:
                    bp_sh <= {tdi, bp_sh[odj_pkg::BPCH_W-1:1]};
                odj_pkg::IR_DBG1:
                    ins_sh <= {tdi, ins_sh[odj_pkg::INSCH_W-1:1]};
                odj_pkg::IR_DBG2, odj_pkg::IR_DBG3:
                    dm_sh <= {tdi, dm_sh[odj_pkg::DMSG_W-1:1]};
                default: ;
            endcase
        end else if (ts == TS_CAPDR && ir == odj_pkg::IR_DBG2) begin
            // Debugger reads channel byte; dirty flag shown in the MSB
            dm_sh <= {dirty_t[1], byte_t[6:0]};
        end
    end

    // Update-DR loads the chains into working copies
    always_ff @(posedge tck) begin
        if (ts == TS_RESET) begin
            bp_cfg_t <= '0;
            bp_tog   <= 1'b0;
            dm_ctl   <= '0;
            clr_tog  <= 1'b0;
            run_tog  <= 1'b0;
            ins_tog  <= 1'b0;
            ins_hold <= '0;
        end else if (ts == TS_UPDR && is_dbg) begin
            if (ir == odj_pkg::IR_DBG0) begin
                bp_cfg_t <= bp_sh;
                bp_tog   <= ~bp_tog;
            end
            if (ir == odj_pkg::IR_DBG1 && ins_sh[0]) begin
                ins_hold <= ins_sh[odj_pkg::INSCH_W-1:1];
                ins_tog  <= ~ins_tog;
            end
            if (ir == odj_pkg::IR_DBG3) begin
                dm_ctl <= dm_sh[2:0];
                if (dm_sh[odj_pkg::DM_CLR_BIT])
                    clr_tog <= ~clr_tog;
                if (dm_sh[odj_pkg::DM_RUN_BIT])
                    run_tog <= ~run_tog;
            end
        end
    end

    // Shift data leaves on the falling edge
    always_ff @(negedge tck) begin
        if (!port_en_t) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_oe <= (ts == TS_SHDR) || (ts == TS_SHIR);
            if (ts == TS_SHIR)
                tdo <= ir_sh[0];
            else if (!is_dbg)
                tdo <= byp;
            else if (ir == odj_pkg::IR_DBG0)
                tdo <= bp_sh[0];
            else if (ir == odj_pkg::IR_DBG1)
                tdo <= ins_sh[0];
            else
                tdo <= dm_sh[0];
        end
    end

    // ************************************************************
    // System clock domain: crossings
    // ************************************************************
    logic [3:0] tog_s, tog_d;
    logic       acc_s;
    logic       bp_ev, clr_ev, run_ev, ins_ev;
    odj_pkg::odj_bp_cfg_t bp_cfg;

    odj_sync #(.W(5)) u_sync_sys (
        .clk  (clk_sys),
        .rst  (rst),
        .din  ({bp_tog, clr_tog, run_tog, ins_tog,
                dm_ctl[odj_pkg::DM_ACC_BIT]}),
        .dout ({tog_s, acc_s})
    );

    always_ff @(posedge clk_sys) begin
        if (rst)
            tog_d <= '0;
        else
            tog_d <= tog_s;
    end
    assign {bp_ev, clr_ev, run_ev, ins_ev} = tog_s ^ tog_d;

    // Wide words are quiet when their toggle is seen two cycles later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bp_cfg     <= '0;
            instr_word <= '0;
        end else begin
            if (ins_ev)
                instr_word <= ins_hold;
            if (bp_ev)
                bp_cfg <= bp_cfg_t;
        end
    end

    // ************************************************************
    // Message byte and dirty flag
    // ************************************************************
    logic [7:0] msg_byte;
    logic       dirty;

    assign io_hit = io_sel & debug_enable_fuse & acc_s;

    always_ff @(posedge clk_sys) begin
        if (rst)
            msg_byte <= '0;
        else if (io_hit && io_wr)
            msg_byte <= io_wdata;
    end

    // CPU write sets the flag; set wins over a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (rst)
            dirty <= 1'b0;
        else if (io_hit && io_wr)
            dirty <= 1'b1;
        else if (clr_ev)
            dirty <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            io_rdata <= '0;
        else if (io_hit && io_rd)
            io_rdata <= {dirty, msg_byte[6:0]};
    end

    always_ff @(posedge tck) begin
        dirty_t <= {dirty_t[0], dirty};
        byte_t  <= msg_byte;
    end

    // ************************************************************
    // Break point unit
    // ************************************************************
    logic [3:0]              hit;
    logic [odj_pkg::ADDR_W-1:0] mask;
    logic                    rng_p, rng_d, brk;
    assign mask  = ~bp_cfg.cbp1;
    assign rng_p = bp_cfg.mode == odj_pkg::ODJ_BP_2P_RNGP;
    assign rng_d = bp_cfg.mode == odj_pkg::ODJ_BP_2P_RNGD;

    always_comb begin
        hit[0] = cpu_trace.fetch && cpu_trace.pc == bp_cfg.pbp0;
        hit[1] = cpu_trace.fetch && cpu_trace.pc == bp_cfg.pbp1;
        hit[2] = 1'b0;
        hit[3] = 1'b0;
        case (bp_cfg.mode)
            odj_pkg::ODJ_BP_4P: begin
                hit[2] = cpu_trace.fetch && cpu_trace.pc == bp_cfg.cbp0;
                hit[3] = cpu_trace.fetch && cpu_trace.pc == bp_cfg.cbp1;
            end
            odj_pkg::ODJ_BP_3P1D: begin
                hit[2] = cpu_trace.fetch && cpu_trace.pc == bp_cfg.cbp0;
                hit[3] = cpu_trace.data_acc
                      && cpu_trace.data_addr == bp_cfg.cbp1;
            end
            odj_pkg::ODJ_BP_2P2D: begin
                hit[2] = cpu_trace.data_acc
                      && cpu_trace.data_addr == bp_cfg.cbp0;
                hit[3] = cpu_trace.data_acc
                      && cpu_trace.data_addr == bp_cfg.cbp1;
            end
            odj_pkg::ODJ_BP_2P_RNGP, odj_pkg::ODJ_BP_2P_RNGD: begin
                // Pair acts as one range: cbp1 set bits are don't-care
                hit[2] = rng_p && cpu_trace.fetch
                      && ((cpu_trace.pc ^ bp_cfg.cbp0) & mask)
                         == odj_pkg::ADDR_ZERO;
                hit[3] = rng_d && cpu_trace.data_acc
                      && ((cpu_trace.data_addr ^ bp_cfg.cbp0) & mask)
                         == odj_pkg::ADDR_ZERO;
            end
            default: ;
        endcase
    end

    assign brk = |(hit & bp_cfg.bp_en)
               | (bp_cfg.flow_break & cpu_trace.flow_change)
               | (bp_cfg.step_break & cpu_trace.fetch);

    // Halt holds until the debugger resumes the CPU or debug becomes disabled
    always_ff @(posedge clk_sys) begin
        if (rst || !dbg_en)
            cpu_halt <= 1'b0;
        else if (brk)
            cpu_halt <= 1'b1;
        else if (run_ev)
            cpu_halt <= 1'b0;
    end

    // Injected word executes only while halted
    always_ff @(posedge clk_sys) begin
        if (rst)
            instr_valid <= 1'b0;
        else
            instr_valid <= ins_ev & cpu_halt & dbg_en;
    end

endmodule : odj_debug_channel

// [rtl/odj_pkg.sv]
/*
 * Shared constants and carrier types for the on-chip debug test channel.
 * Assumes a 4-bit test instruction register and an 8-bit CPU data path.
 */
package odj_pkg;

    localparam int IR_W     = 4;
    localparam int BYTE_W   = 8;
    localparam int ADDR_W   = 16;
    localparam int DMSG_W   = 8;   // Debug message chain length
    localparam int BPCH_W   = 73;  // Break point chain: full config word
    localparam int INSCH_W  = 17;  // Instruction scan chain: valid + 16 bit

    // Test instruction codes
    localparam logic [IR_W-1:0] IR_DBG0   = 4'h8;
    localparam logic [IR_W-1:0] IR_DBG1   = 4'h9;
    localparam logic [IR_W-1:0] IR_DBG2   = 4'ha;
    localparam logic [IR_W-1:0] IR_DBG3   = 4'hb;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPT   = 4'h1; // Captured IR pattern

    // Break point unit configuration modes
    typedef enum logic [2:0] {
        ODJ_BP_4P     = 3'b000,
        ODJ_BP_3P1D   = 3'b001,
        ODJ_BP_2P2D   = 3'b010,
        ODJ_BP_2P_RNGP = 3'b011,
        ODJ_BP_2P_RNGD = 3'b100
    } odj_bp_mode_t;

    // Break point configuration word, loaded from the break point chain
    typedef struct packed {
        logic                 flow_break;
        logic                 step_break;
        odj_bp_mode_t         mode;
        logic [3:0]           bp_en;
        logic [ADDR_W-1:0]    pbp0;
        logic [ADDR_W-1:0]    pbp1;
        logic [ADDR_W-1:0]    cbp0;
        logic [ADDR_W-1:0]    cbp1;
    } odj_bp_cfg_t;

    // CPU trace presented to the break point unit every cycle
    typedef struct packed {
        logic              fetch;
        logic [ADDR_W-1:0] pc;
        logic              flow_change;
        logic              data_acc;
        logic [ADDR_W-1:0] data_addr;
    } odj_cpu_trace_t;

    // Bit positions inside the debug message chain control
    localparam int DM_CLR_BIT = 0; // Clears the dirty flag
    localparam int DM_ACC_BIT = 1; // Enables CPU access to the channel byte
    localparam int DM_RUN_BIT = 2; // Resumes the halted CPU

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

endpackage : odj_pkg

// [rtl/odj_sync.sv]
/*
 * Two-flop level synchroniser with a parameterised width.
 * Assumes each bit is a slow level or a toggle; words are not coherent.
 */
`timescale 1ns/1ps
module odj_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : odj_sync

// [test/odj_probe.sv]
/*
 * Behavioural debug probe driving the four test pins.
 * Assumes the serial output line is pulled up by the bench.
 */
`timescale 1ns/1ps
module odj_probe (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo_line
);
    // ****************************************
    // Pin driving
    // ****************************************
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Clock idles low between frames; pins change after a falling edge
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        tck = 1'b1;
        q = tdo_line;
        #62.5;
        tck = 1'b0;
    endtask : pulse
    task automatic to_idle();
        logic q;
        repeat (5) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask : to_idle
    // From idle: shift n bits into IR or DR, back to idle
    task automatic scan(input logic ir, input logic [72:0] din,
                        input int n, output logic [72:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, ~tdi, q);
        if (ir) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        tdi = ~tdi;
    endtask : scan
endmodule : odj_probe

// [test/odj_props.sv]
/*
 * Checker for the debug channel, bound to its top module.
 * Assumes fuses and lock bits are slow levels and rst is synchronous.
 */
`timescale 1ns/1ps
module odj_props (
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire logic                    tck,
    input wire logic                    tms,
    input wire logic                    tdi,
    input wire logic                    tdo,
    input wire logic                    tdo_oe,
    input wire logic                    test_port_enable_fuse,
    input wire logic                    debug_enable_fuse,
    input wire logic                    test_port_disable_bit,
    input wire logic                    lock_bit_one,
    input wire logic                    lock_bit_two,
    input wire logic                    chip_erase_done,
    input wire logic                    fuse_prog_req,
    input wire logic                    fuse_prog_grant,
    input wire odj_pkg::odj_cpu_trace_t cpu_trace,
    input wire logic                    io_wr,
    input wire logic                    io_rd,
    input wire logic                    io_sel,
    input wire logic [7:0]              io_wdata,
    input wire logic [7:0]              io_rdata,
    input wire logic                    io_hit,
    input wire logic                    cpu_halt,
    input wire logic                    instr_valid,
    input wire logic [15:0]             instr_word
);
    // ****************************************
    // Helper state
    // ****************************************
    logic       erase_q;
    logic [7:0] wd_q;
    // Unlock lasts until the locks themselves are gone
    always_ff @(posedge clk_sys) begin
        if (rst)
            erase_q <= 1'b0;
        else if (chip_erase_done)
            erase_q <= 1'b1;
        else if (!lock_bit_one && !lock_bit_two)
            erase_q <= 1'b0;
    end
    always_ff @(posedge clk_sys) begin
        if (io_hit && io_wr)
            wd_q <= io_wdata;
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_grant_locked;
        @(posedge clk_sys) disable iff (rst)
        (lock_bit_one || lock_bit_two) && fuse_prog_req && !erase_q
            && !chip_erase_done |-> !fuse_prog_grant;
    endproperty
    a_grant_locked: assert property (p_grant_locked)
        else $error("fuse grant while locked");
    property p_grant_free;
        @(posedge clk_sys) disable iff (rst)
        fuse_prog_req && !lock_bit_one && !lock_bit_two |-> fuse_prog_grant;
    endproperty
    a_grant_free: assert property (p_grant_free)
        else $error("fuse grant missing");
    property p_grant_idle;
        @(posedge clk_sys) disable iff (rst) !fuse_prog_req |-> !fuse_prog_grant;
    endproperty
    a_grant_idle: assert property (p_grant_idle)
        else $error("fuse grant without request");
    property p_hit_gate;
        @(posedge clk_sys) disable iff (rst)
        io_hit |-> io_sel && debug_enable_fuse;
    endproperty
    a_hit_gate: assert property (p_hit_gate)
        else $error("channel hit without select and fuse");
    property p_wr_rd;
        @(posedge clk_sys) disable iff (rst)
        (io_hit && io_wr) ##1 (io_hit && io_rd)
            |=> io_rdata == {1'b1, wd_q[6:0]};
    endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("read after write lacks byte or dirty flag");
    property p_rdata_stand;
        @(posedge clk_sys) disable iff (rst)
        !$past(io_hit && io_rd) |-> $stable(io_rdata);
    endproperty
    a_rdata_stand: assert property (p_rdata_stand)
        else $error("read data moved without a read");
    property p_valid_halted;
        @(posedge clk_sys) disable iff (rst) instr_valid |-> cpu_halt;
    endproperty
    a_valid_halted: assert property (p_valid_halted)
        else $error("injected word while running");
    property p_halt_gate;
        @(posedge clk_sys) disable iff (rst)
        $rose(cpu_halt) |->
            $past(debug_enable_fuse && !lock_bit_one && !lock_bit_two);
    endproperty
    a_halt_gate: assert property (p_halt_gate)
        else $error("halt while debug disabled");
    property p_oe_disabled;
        @(posedge tck) disable iff (rst)
        test_port_disable_bit [*5] |-> !tdo_oe;
    endproperty
    a_oe_disabled: assert property (p_oe_disabled)
        else $error("serial output driven while port disabled");
endmodule : odj_props

bind odj_debug_channel odj_props i_odj_props (.clk_sys, .rst, .tck, .tms,
    .tdi, .tdo, .tdo_oe, .test_port_enable_fuse, .debug_enable_fuse,
    .test_port_disable_bit, .lock_bit_one, .lock_bit_two, .chip_erase_done,
    .fuse_prog_req, .fuse_prog_grant, .cpu_trace, .io_wr, .io_rd, .io_sel,
    .io_wdata, .io_rdata, .io_hit, .cpu_halt, .instr_valid, .instr_word);

// [test/testbench.sv]
/*
 * Self-checking bench for the debug channel with a probe model.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module testbench;
    logic clk_sys, rst, tck, tms, tdi, tdo, tdo_oe, tdo_line, seen, hit;
    logic port_fuse, dbg_fuse, port_off, lock1, lock2, erase, req, grant;
    logic io_wr, io_rd, io_sel, io_hit, cpu_halt, instr_valid;
    logic [7:0] io_wdata, io_rdata;
    logic [15:0] instr_word, word;
    logic [72:0] got;
    odj_pkg::odj_cpu_trace_t cpu_trace;
    odj_pkg::odj_bp_cfg_t cfg;
    int miscompares, checks_done, cycles;
    // Rows: lock one, lock two, request, expected grant
    logic [3:0] rows [0:7] = '{4'h0, 4'h3, 4'h8, 4'ha, 4'h4, 4'h6, 4'hc, 4'he};
    assign tdo_line = tdo_oe ? tdo : 1'b1; // Board pull-up
    odj_debug_channel i_odj_debug_channel (.clk_sys, .rst, .tck, .tms, .tdi,
        .tdo, .tdo_oe, .test_port_enable_fuse(port_fuse),
        .debug_enable_fuse(dbg_fuse), .test_port_disable_bit(port_off),
        .lock_bit_one(lock1), .lock_bit_two(lock2), .chip_erase_done(erase),
        .fuse_prog_req(req), .fuse_prog_grant(grant), .cpu_trace, .io_wr,
        .io_rd, .io_sel, .io_wdata, .io_rdata, .io_hit, .cpu_halt,
        .instr_valid, .instr_word);
    odj_probe i_odj_probe (.tck, .tms, .tdi, .tdo_line);
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [72:0] s, input logic [72:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic io(input logic wr, input logic [7:0] d);
        @(posedge clk_sys);
        io_sel <= 1'b1;
        io_wr <= wr;
        io_rd <= ~wr;
        io_wdata <= d;
        #1 hit = io_hit;
        @(posedge clk_sys);
        io_sel <= 1'b0;
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : io
    task automatic op(input logic [3:0] ir, input logic [72:0] d, input int n);
        i_odj_probe.scan(1'b1, 73'(ir), 4, got);
        i_odj_probe.scan(1'b0, d, n, got);
        repeat (10) @(posedge clk_sys);
    endtask : op
    task automatic fetch(input logic [15:0] pc);
        @(posedge clk_sys);
        cpu_trace.fetch <= 1'b1;
        cpu_trace.pc <= pc;
        @(posedge clk_sys);
        cpu_trace.fetch <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : fetch
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, port_fuse, dbg_fuse} = 3'b111;
        {port_off, lock1, lock2, erase, req} = 5'h0;
        {io_wr, io_rd, io_sel, io_wdata} = 11'h0;
        cpu_trace = '0;
        repeat (20) @(posedge clk_sys);
        #1 check({cpu_halt, instr_valid, io_hit, grant}, 4'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        i_odj_probe.to_idle();
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {lock1, lock2, req} <= rows[i][3:1];
            @(posedge clk_sys);
            #1 check(grant, rows[i][0]);
        end
        @(posedge clk_sys);
        {lock1, lock2, req, erase} <= 4'hb;
        @(posedge clk_sys);
        erase <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check(grant, 1'b1);
        {lock1, req} <= 2'b00;
        io(1'b1, 8'h55);
        check(hit, 1'b0);
        i_odj_probe.scan(1'b1, 73'(odj_pkg::IR_DBG3), 4, got);
        check(got[3:0], odj_pkg::IR_CAPT);
        i_odj_probe.scan(1'b0, 73'h02, 8, got);
        repeat (11) @(posedge clk_sys);
        {io_sel, io_wr, io_wdata} <= 10'h33a;
        @(posedge clk_sys);
        {io_wr, io_rd} <= 2'b01;
        @(posedge clk_sys);
        {io_sel, io_rd} <= 2'b00;
        @(posedge clk_sys);
        #1 check(io_rdata, 8'hba);
        op(odj_pkg::IR_DBG2, 73'h0, 8);
        check(got[7:0], 8'hba);
        op(odj_pkg::IR_DBG3, 73'h03, 8);
        io(1'b0, 8'h00);
        check({hit, io_rdata}, 9'h13a);
        dbg_fuse <= 1'b0;
        io(1'b1, 8'h11);
        check(hit, 1'b0);
        dbg_fuse <= 1'b1;
        cfg = '0;
        cfg.mode = odj_pkg::ODJ_BP_4P;
        cfg.bp_en = 4'h1;
        cfg.pbp0 = 16'h0040;
        op(odj_pkg::IR_DBG0, cfg, odj_pkg::BPCH_W);
        lock2 <= 1'b1;
        fetch(16'h0040);
        check(cpu_halt, 1'b0);
        lock2 <= 1'b0;
        fetch(16'h0041);
        check(cpu_halt, 1'b0);
        fetch(16'h0040);
        check(cpu_halt, 1'b1);
        i_odj_probe.scan(1'b1, 73'(odj_pkg::IR_DBG1), 4, got);
        seen = 1'b0;
        word = 16'h0;
        fork
            i_odj_probe.scan(1'b0, 73'h2469, 17, got);
            for (int k = 0; k < 80 && seen !== 1'b1; k++) begin
                @(posedge clk_sys);
                #1 seen = instr_valid;
                word = instr_word;
            end
        join
        check({seen, word}, 17'h11234);
        op(odj_pkg::IR_DBG3, 73'h06, 8);
        check(cpu_halt, 1'b0);
        port_off <= 1'b1;
        i_odj_probe.scan(1'b1, 73'h0, 4, got);
        check(got[3:0], 4'hf);
        complete_run();
    end
endmodule : testbench
